// ---- srp_packer.sv ----
// Contract
// - length zero means no length limit
// - length hit emits chunk at once
// - marker bytes zero both disable markers
// - no marker: forward every byte at once
// - marker set: accumulate until marker, send all
// - second marker zero means single-character marker
// - full 1K buffer flushes and empties
// - timeout zero disables idle flush
// - idle timeout expiry flushes buffered bytes
// - one-byte match: either marker triggers
// - two-byte match: first then second triggers
// - match count defaults to two bytes
// - trailer only with first marker, full match
// - trailer waits zero, one or two bytes
// - trailer defaults to none
`timescale 1ns/10ps
module srp_packer #(
  parameter int CLK_HZ   = srp_pkg::CLK_HZ_DEF,
  parameter int TICK_CYC = CLK_HZ / srp_pkg::MS_PER_S * srp_pkg::TICK_MS
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [srp_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [srp_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [srp_pkg::DAT_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_data,
  output logic                           rx_ready,
  output logic                           tx_valid,
  output logic      [7:0]                tx_data,
  output logic                           tx_last,
  input  wire logic                      tx_ready
);
  import srp_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  srp_mem_if #(.DEPTH(BUF_DEPTH)) mif ();
  srp_tmr_if                      tif ();

  srp_buf #(.DEPTH(BUF_DEPTH)) u_buf (
    .clk (clk),
    .m   (mif)
  );

  srp_idle_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
    .clk (clk),
    .rst (rst),
    .t   (tif)
  );

  // ------------------------------------------------------------------
  // settings and state
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] max_len_r;
  logic [7:0]       d1_r;
  logic [7:0]       d2_r;
  logic             two_r;
  logic [1:0]       proc_r;
  logic [15:0]      tout_r;
  srp_state_t       state_r;
  srp_state_t       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] rd_r;
  logic [1:0]       trail_r;
  logic [1:0]       trail_nxt;
  logic             prev_d1_r;
  logic             ack_r;
  logic [31:0]      dat_r;
  logic             rdy_r;
  logic             txv_r;
  logic [7:0]       txd_r;
  logic             txl_r;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire        bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  wire        bus_wr   = bus_req && wb_we_i;
  wire [31:0] len_word = {21'h000000, max_len_r};
  wire [31:0] mark_word = {13'h0000, proc_r, two_r, d2_r, d1_r};
  wire [31:0] tout_word = {16'h0000, tout_r};
  wire [31:0] stat_word = {15'h0000, state_r == ST_DRAIN, 5'h00, cnt_r};
  wire [31:0] len_wr   = srp_merge(len_word, wb_dat_i, wb_sel_i);
  wire [31:0] mark_wr  = srp_merge(mark_word, wb_dat_i, wb_sel_i);
  wire [31:0] tout_wr  = srp_merge(tout_word, wb_dat_i, wb_sel_i);
  wire        len_big  = (len_wr > 32'(BUF_DEPTH));
  wire [31:0] rd_word  = (wb_adr_i == REG_LEN)  ? len_word  :
                         (wb_adr_i == REG_MARK) ? mark_word :
                         (wb_adr_i == REG_TOUT) ? tout_word :
                         (wb_adr_i == REG_STAT) ? stat_word : 32'h00000000;

  // ------------------------------------------------------------------
  // close conditions
  // ------------------------------------------------------------------
  wire             rx_fire  = rx_valid && rdy_r;
  wire [CNT_W-1:0] cnt_inc  = cnt_r + CNT_ONE;
  wire             mark_en  = (d1_r != 8'h00) || (d2_r != 8'h00);
  wire             len_hit  = (max_len_r != LEN_RST) && (cnt_inc == max_len_r);
  wire             full_hit = (cnt_inc == CNT_FULL);
  wire             two_seq  = two_r && (d1_r != 8'h00) && (d2_r != 8'h00);
  wire             one_hit  = ((d1_r != 8'h00) && (rx_data == d1_r)) ||
                              ((d2_r != 8'h00) && (rx_data == d2_r));
  wire             seq_hit  = prev_d1_r && (rx_data == d2_r);
  wire             mark_hit = mark_en && (two_seq ? seq_hit : one_hit);
  wire             trailing = (trail_r != PROC_NONE);
  wire             use_trl  = (d1_r != 8'h00) && (proc_r != PROC_NONE);
  wire             trl_done = trailing && (trail_r == 2'h1);
  wire             mark_cls = mark_hit && !trailing && !use_trl;
  wire             byte_cls = !mark_en || len_hit || full_hit ||
                              trl_done || mark_cls;
  wire             tmo_cls  = (state_r == ST_FILL) && (cnt_r != '0) &&
                              tif.expired && !rx_fire;
  wire             close    = (rx_fire && byte_cls) || tmo_cls;

  // ------------------------------------------------------------------
  // drain path
  // ------------------------------------------------------------------
  wire drain    = (state_r == ST_DRAIN);
  wire load     = drain && (rd_r < cnt_r) && (!txv_r || tx_ready);
  wire pop_last = drain && txv_r && tx_ready && txl_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    trail_nxt = trail_r;
    if (rx_fire) begin
      cnt_nxt = cnt_inc;
      if (byte_cls) begin
        trail_nxt = PROC_NONE;
      end else if (trailing) begin
        trail_nxt = trail_r - 2'h1;
      end else if (mark_hit) begin
        trail_nxt = proc_r;
      end
    end
    if (close) begin
      state_nxt = ST_DRAIN;
    end else if (pop_last) begin
      state_nxt = ST_FILL;
      cnt_nxt   = '0;
    end
  end

  assign mif.we        = rx_fire;
  assign mif.waddr     = cnt_r[AW-1:0];
  assign mif.wdata     = rx_data;
  assign mif.raddr     = rd_r[AW-1:0];
  assign tif.byte_seen = rx_fire;
  assign tif.hold      = (cnt_r == '0) || drain;
  assign tif.limit     = tout_r;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      max_len_r <= LEN_RST;
      d1_r      <= MARK_RST;
      d2_r      <= MARK_RST;
      two_r     <= TWO_RST;
      proc_r    <= PROC_RST;
      tout_r    <= TOUT_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == REG_LEN) begin
        max_len_r <= len_big ? CNT_FULL : len_wr[CNT_W-1:0];
      end
      if (wb_adr_i == REG_MARK) begin
        d1_r   <= mark_wr[MARK_D1_LSB +: 8];
        d2_r   <= mark_wr[MARK_D2_LSB +: 8];
        two_r  <= mark_wr[MARK_TWO_BIT];
        proc_r <= (mark_wr[MARK_PROC_LSB +: 2] == 2'h3) ? 2'h2 : mark_wr[MARK_PROC_LSB +: 2];
      end
      if (wb_adr_i == REG_TOUT) begin
        tout_r <= tout_wr[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      dat_r <= bus_req ? rd_word : 32'h00000000;
    end
  end

  // ------------------------------------------------------------------
  // packing state
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_FILL;
      cnt_r     <= '0;
      trail_r   <= PROC_NONE;
      prev_d1_r <= 1'b0;
      rdy_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      trail_r   <= trail_nxt;
      prev_d1_r <= rx_fire ? (rx_data == d1_r) : prev_d1_r;
      rdy_r     <= (state_nxt == ST_FILL);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_r  <= '0;
      txv_r <= 1'b0;
      txd_r <= 8'h00;
      txl_r <= 1'b0;
    end else if (load) begin
      rd_r  <= rd_r + CNT_ONE;
      txv_r <= 1'b1;
      txd_r <= mif.rdata;
      txl_r <= (rd_r + CNT_ONE == cnt_r);
    end else if (txv_r && tx_ready) begin
      txv_r <= 1'b0;
      txl_r <= 1'b0;
      rd_r  <= txl_r ? '0 : rd_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rx_ready = rdy_r;
  assign tx_valid = txv_r;
  assign tx_data  = txd_r;
  assign tx_last  = txl_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_plain_byte;
    rx_fire && mark_en && !len_hit && !full_hit && !trailing;
  endsequence

  sequence s_enter_drain(logic [CNT_W-1:0] n);
    state_r == ST_DRAIN && cnt_r == n && !rx_ready;
  endsequence

  sequence s_tx_wait;
    tx_valid && !tx_ready;
  endsequence

  chk_len_close: assert property (rx_fire && len_hit |=> s_enter_drain(max_len_r))
    else $error("length limit did not close chunk");
  chk_zero_len: assert property (s_plain_byte and max_len_r == LEN_RST && !mark_hit
                                 |=> state_r == ST_FILL)
    else $error("chunk closed without cause");
  chk_nomark_fwd: assert property (rx_fire && !mark_en && cnt_r == '0
                                   |=> s_enter_drain(CNT_ONE))
    else $error("byte not forwarded at once");
  chk_full_flush: assert property (rx_fire && full_hit |=> s_enter_drain(CNT_FULL))
    else $error("full buffer not flushed");
  chk_one_either: assert property (s_plain_byte and !two_r && one_hit && !use_trl
                                   |=> state_r == ST_DRAIN)
    else $error("single marker missed");
  chk_two_order: assert property (s_plain_byte and two_seq && !seq_hit
                                  |=> state_r == ST_FILL)
    else $error("marker pair closed out of order");
  chk_trail_wait: assert property (s_plain_byte and mark_hit && use_trl
                                   |=> state_r == ST_FILL && trail_r == $past(proc_r))
    else $error("trailer count not armed");
  chk_idle_flush: assert property (tmo_cls |=> state_r == ST_DRAIN ##0 cnt_r == $past(cnt_r))
    else $error("idle timeout did not flush");
  chk_drain_empty: assert property (pop_last |=> state_r == ST_FILL && cnt_r == '0)
    else $error("buffer not emptied after chunk");
  chk_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  // ------------------------------------------------------------------
  // stream checks
  // ------------------------------------------------------------------
  chk_tx_hold: assert property (s_tx_wait |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("chunk byte changed before taken");
  chk_first_byte: assert property (close |-> ##2 tx_valid && rd_r == CNT_ONE)
    else $error("chunk not started after close");
  chk_drain_held: assert property (drain && !pop_last |=> drain)
    else $error("drain left before last byte");
  chk_last_index: assert property (tx_valid && tx_last |-> rd_r == cnt_r)
    else $error("last flag not on final byte");
  chk_reopen: assert property (pop_last |=> rx_ready)
    else $error("serial input not reopened");
  chk_trail_step: assert property (rx_fire && mark_en && !len_hit && !full_hit
                                   && trail_r == 2'h2
                                   |=> state_r == ST_FILL && trail_r == 2'h1)
    else $error("trailer count not stepped");
  chk_trail_end: assert property (rx_fire && trail_r == 2'h1 |=> state_r == ST_DRAIN)
    else $error("trailer end did not close chunk");
endmodule

// ---- srp_pkg.sv ----
package srp_pkg;
  // ------------------------------------------------------------------
  // buffer and bus geometry
  // ------------------------------------------------------------------
  localparam int          BUF_DEPTH     = 1024;
  localparam int          CNT_W         = 11;
  localparam int          ADR_W         = 8;
  localparam int          DAT_W         = 32;
  // ------------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_LEN       = 8'h00;
  localparam logic [7:0]  REG_MARK      = 8'h04;
  localparam logic [7:0]  REG_TOUT      = 8'h08;
  localparam logic [7:0]  REG_STAT      = 8'h0C;
  localparam int          MARK_D1_LSB   = 0;
  localparam int          MARK_D2_LSB   = 8;
  localparam int          MARK_TWO_BIT  = 16;
  localparam int          MARK_PROC_LSB = 17;
  localparam int          STAT_BUSY_BIT = 16;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [10:0] LEN_RST       = 11'h000;
  localparam logic [7:0]  MARK_RST      = 8'h00;
  localparam logic        TWO_RST       = 1'b1;
  localparam logic [1:0]  PROC_RST      = 2'h0;
  localparam logic [15:0] TOUT_RST      = 16'h0000;
  localparam logic [1:0]  PROC_NONE     = 2'h0;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CLK_HZ_DEF    = 50_000_000;
  localparam int          TICK_MS       = 1;
  localparam int          MS_PER_S      = 1000;

  typedef enum logic [0:0] {
    ST_FILL  = 1'b0,
    ST_DRAIN = 1'b1
  } srp_state_t;

  function automatic logic [31:0] srp_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction
endpackage

// ---- srp_if.sv ----
`timescale 1ns/10ps
interface srp_mem_if #(parameter int DEPTH = 1024);
  logic                     we;
  logic [$clog2(DEPTH)-1:0] waddr;
  logic [7:0]               wdata;
  logic [$clog2(DEPTH)-1:0] raddr;
  logic [7:0]               rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

interface srp_tmr_if;
  logic        byte_seen;
  logic        hold;
  logic [15:0] limit;
  logic        expired;
  modport ctl (output byte_seen, hold, limit, input expired);
  modport tmr (input byte_seen, hold, limit, output expired);
endinterface

// ---- srp_buf.sv ----
`timescale 1ns/10ps
module srp_buf #(
  parameter int DEPTH = 1024
) (
  input  wire logic   clk,
  srp_mem_if.mem      m
);
  logic [7:0] mem_r [DEPTH];

  // ------------------------------------------------------------------
  // byte storage
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (m.we) begin
      mem_r[m.waddr] <= m.wdata;
    end
  end

  assign m.rdata = mem_r[m.raddr];
endmodule

// ---- srp_idle_timer.sv ----
`timescale 1ns/10ps
module srp_idle_timer #(
  parameter int TICK_CYC = 50000
) (
  input  wire logic   clk,
  input  wire logic   rst,
  srp_tmr_if.tmr      t
);
  import srp_pkg::*;

  localparam int DW = $clog2(TICK_CYC);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYC - 1);

  logic [DW-1:0] div_r;
  logic [15:0]   ms_r;
  logic          exp_r;
  wire           tick   = (div_r == DIV_LAST);
  wire           clr    = t.hold | t.byte_seen;
  wire           at_lim = (t.limit != 16'h0000) && (ms_r >= t.limit);

  // ------------------------------------------------------------------
  // millisecond divider and idle count
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
      ms_r  <= 16'h0000;
      exp_r <= 1'b0;
    end else begin
      div_r <= (clr | tick) ? '0 : div_r + 1'b1;
      if (clr) begin
        ms_r <= 16'h0000;
      end else if (tick && !at_lim) begin
        ms_r <= ms_r + 16'h0001;
      end
      exp_r <= !clr && at_lim;
    end
  end

  assign t.expired = exp_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_timer_hold_clear: assert property (t.hold |=> ms_r == 16'h0000)
    else $error("idle count not cleared while held");
  chk_timer_zero_off: assert property (t.limit == 16'h0000 |=> !exp_r)
    else $error("timeout fired while disabled");
endmodule

// ---- srp_src.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// serial byte source
// ------------------------------------------------------------------
module srp_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  logic [7:0] q[$];
  wire        took = rx_valid && rx_ready;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      if (took) begin
        void'(q.pop_front());
      end
      // an offered byte is held until taken; slow mode inserts gaps only
      if (q.size() > 0 && (!slow || ($urandom % 2) == 0 || (rx_valid && !took))) begin
        rx_valid <= 1'b1;
        rx_data  <= q[0];
      end else begin
        rx_valid <= 1'b0;
        // released data line keeps moving
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule

// ---- serial_rx_data_packer_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module serial_rx_data_packer_tb;
  import srp_pkg::*;
  logic        clk, rst, wb_cyc, wb_stb, wb_we, tx_ready, slow;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic        wb_ack_o, rx_valid, rx_ready, tx_valid, tx_last;
  logic [7:0]  rx_data, tx_data, xb;
  logic [7:0]  mb[$], exp_b[$], c_d1, c_d2;
  logic        exp_l[$], xl, c_two;
  int          fail_count, check_count, c_len, c_proc, tcnt;
  logic [7:0]  md1[6] = '{8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h00};
  logic [7:0]  md2[6] = '{8'h00, 8'h0A, 8'h0A, 8'h00, 8'h0A, 8'h0A};
  logic        mtw[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int          mpr[6] = '{0, 0, 0, 1, 2, 1};
  logic [7:0]  stim[15] = '{8'h41, 8'h42, 8'h43, 8'h0A, 8'h44, 8'h0D, 8'h45, 8'h0A,
                            8'h46, 8'h47, 8'h0D, 8'h0A, 8'h48, 8'h49, 8'h4A};

  srp_packer #(.TICK_CYC(10)) u_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  srp_src u_src (.clk(clk), .rst(rst), .slow(slow), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) tx_ready <= ($urandom % 4) != 0;

  // ------------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------------
  task automatic mclose();
    foreach (mb[i]) begin
      exp_b.push_back(mb[i]);
      exp_l.push_back(i == mb.size() - 1);
    end
    mb.delete();
    tcnt = 0;
  endtask

  task automatic put(input logic [7:0] b);
    logic       hit;
    logic [7:0] pv;
    u_src.q.push_back(b);
    pv = (mb.size() > 0) ? mb[$] : 8'h00;
    mb.push_back(b);
    if (c_d1 == 8'h00 && c_d2 == 8'h00) begin
      mclose();
      return;
    end
    if ((c_len != 0 && mb.size() == c_len) || mb.size() == BUF_DEPTH) begin
      mclose();
      return;
    end
    if (tcnt > 0) begin
      tcnt--;
      if (tcnt == 0) mclose();
      return;
    end
    if (c_d1 != 8'h00 && c_d2 != 8'h00)
      hit = c_two ? (pv == c_d1 && b == c_d2) : (b == c_d1 || b == c_d2);
    else
      hit = (c_d1 != 8'h00) ? (b == c_d1) : (b == c_d2);
    if (hit && c_d1 != 8'h00 && c_proc != 0) tcnt = c_proc;
    else if (hit) mclose();
  endtask

  function automatic logic [7:0] rnd();
    return 8'h20 + 8'($urandom % 64);
  endfunction

  // ------------------------------------------------------------------
  // bus and sequencing tasks
  // ------------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg(input int ln, input logic [7:0] d1, input logic [7:0] d2,
                     input logic two, input int pr);
    c_len = ln;
    c_d1 = d1;
    c_d2 = d2;
    c_two = two;
    c_proc = pr;
    wb(1'b1, REG_LEN, 32'(ln));
    wb(1'b1, REG_MARK, {13'h0000, 2'(pr), two, d2, d1});
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while ((u_src.q.size() > 0 || exp_b.size() > 0 || rx_ready !== 1'b1) && n < 10000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 10000) fail_count++;
  endtask

  task automatic tflush(input logic [31:0] ms);
    mclose();
    wb(1'b1, REG_TOUT, ms);
    wait_done();
    wb(1'b1, REG_TOUT, 32'h0000_0000);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready) begin
      `CHK("rx_hold", 1'b0, rx_ready)
      if (exp_b.size() == 0) begin
        `CHK("tx_unexpected", 1'b0, tx_valid)
      end else begin
        xb = exp_b.pop_front();
        xl = exp_l.pop_front();
        `CHK("tx_data", xb, tx_data)
        `CHK("tx_last", xl, tx_last)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(45518));
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, slow} = '0;
    wb_adr = 8'h00;
    wb_dat = 32'h0000_0000;
    tcnt = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_LEN, 32'h0);
    `CHK("len_rst", 32'h0000_0000, rd)
    wb(1'b0, REG_MARK, 32'h0);
    `CHK("mark_rst", 32'h0001_0000, rd)
    wb(1'b0, REG_TOUT, 32'h0);
    `CHK("tout_rst", 32'h0000_0000, rd)
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0000_0000, rd)
    wb(1'b1, REG_LEN, 32'h0000_0800);
    wb(1'b0, REG_LEN, 32'h0);
    `CHK("len_clamp", 32'(BUF_DEPTH), rd)
    $display("test reset_values done");
    cfg(0, 8'h00, 8'h00, 1'b1, 0);
    repeat (6) put(rnd());
    wait_done();
    $display("test no_marker done");
    for (int i = 0; i < 6; i++) begin
      cfg(0, md1[i], md2[i], mtw[i], mpr[i]);
      foreach (stim[j]) put(stim[j]);
      wait_done();
      repeat (100) @(posedge clk);
      `CHK("idle_hold", 1'b0, tx_valid)
      tflush(32'h2);
      $display("test marker_mode %0d done", i);
    end
    cfg(5, 8'h0D, 8'h00, 1'b0, 0);
    repeat (12) put(rnd());
    put(8'h0D);
    wait_done();
    $display("test length_limit done");
    slow <= 1'b1;
    wb(1'b1, REG_TOUT, 32'h5);
    cfg(0, 8'h0D, 8'h0A, 1'b1, 0);
    repeat (1030) put(rnd());
    while (u_src.q.size() > 0) @(posedge clk);
    mclose();
    wait_done();
    wb(1'b0, REG_STAT, 32'h0);
    `CHK("stat_empty", 32'h0000_0000, rd)
    wb(1'b1, REG_TOUT, 32'h0);
    slow <= 1'b0;
    $display("test full_buffer done");
    close_out();
  end
endmodule
